/* File: two_wire_register_read_slave_bench.sv */
/*
 Self-checking bench for the two-wire register slave.
 Assumes twr_master as bus partner and a random register image.
*/
`timescale 1ns/100ps
module two_wire_register_read_slave_bench;
	// ----------------------------------------
	// wiring, clocks, user side
	// ----------------------------------------
	logic clk_in = 1'b0;
	logic nrst_in = 1'b1;
	logic wr_ready_in = 1'b0;
	logic hold = 1'b1;
	logic scl_w, m_oe, s_oe, sda_w, wr_valid, busy, r;
	logic [7:0] rd_addr, q;
	logic [7:0] img [256];
	twr_pkg::wr_req_t wr_req;
	twr_pkg::wr_req_t got_q[$];
	twr_pkg::wr_req_t exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 9;
	assign sda_w = !(m_oe || s_oe); // pull-up: either party pulls low
	always #10 clk_in = !clk_in;
	twr_slave u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .scl_clk_in(scl_w), .sda_in(sda_w),
		.sda_out(), .sda_oe_out(s_oe), .rd_addr_out(rd_addr), .rd_data_in(img[rd_addr]),
		.wr_req_out(wr_req), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready_in),
		.busy_out(busy));
	twr_master u_mst (.sda_in(sda_w), .scl_out(scl_w), .sda_oe_out(m_oe));
	// random stalls on the write side unless held off to fill the buffer
	always @(posedge clk_in) begin
		#1 wr_ready_in = !hold && ($random(seed) % 2 != 0);
	end
	always @(posedge clk_in) if (wr_valid && wr_ready_in) got_q.push_back(wr_req);
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// all-ones once the pointer has run past the top
	function automatic logic [7:0] exp_rd(input int a);
		return (a > 255) ? 8'hFF : img[a];
	endfunction
	// ----------------------------------------
	// transactions
	// ----------------------------------------
	task automatic head(input logic [6:0] ad, input logic [7:0] p);
		u_mst.start_c();
		u_mst.byte_x({ad, 1'b0}, 1'b1, q, r);
		chk(24'(r), 24'(ad != twr_pkg::DEV_ADDR));
		if (ad == twr_pkg::DEV_ADDR) u_mst.byte_x(p, 1'b1, q, r);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		head(twr_pkg::DEV_ADDR, p);
		u_mst.start_c();
		u_mst.byte_x({twr_pkg::DEV_ADDR, 1'b1}, 1'b1, q, r);
		chk(24'(r), 24'h0);
		for (int i = 0; i < n; i++) begin
			u_mst.byte_x(8'hFF, i == n - 1, q, r);
			chk(24'(q), 24'(exp_rd(p + i)));
		end
		chk(24'(s_oe), 24'h0);
	endtask
	// n full pairs, then optionally a lone high byte that must not land
	task automatic wr(input logic [7:0] p, input int n, input logic lone);
		logic [7:0] hi = 8'hA5;
		logic [7:0] lo = 8'h5A;
		head(twr_pkg::DEV_ADDR, p);
		for (int k = 0; k < n; k++) begin
			hi = 8'($random(seed));
			lo = 8'($random(seed));
			u_mst.byte_x(hi, 1'b1, q, r);
			u_mst.byte_x(lo, 1'b1, q, r);
			exp_q.push_back({8'(p + 2 * k), hi, lo});
		end
		if (lone) u_mst.byte_x(hi, 1'b1, q, r);
		u_mst.stop_c();
	endtask
	task automatic drain();
		int t = 0;
		hold = 1'b0;
		while (got_q.size() < exp_q.size() && t < 400) begin
			@(posedge clk_in);
			t++;
		end
		if (got_q.size() < exp_q.size()) begin
			error_cnt++;
			wrap_up();
		end
		repeat (20) @(posedge clk_in);
		chk(24'(got_q.size()), 24'(exp_q.size()));
		foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
		got_q.delete();
		exp_q.delete();
	endtask
	initial begin
		#1000000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		for (int i = 0; i < 256; i++) img[i] = 8'($random(seed));
		// a real falling edge, so the link-side flops see the reset too
		#1 nrst_in = 1'b0;
		repeat (2) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#7;
		head(7'h37, 8'h00);
		u_mst.stop_c();
		wr(8'h10, twr_pkg::FIFO_DEPTH, 1'b0);
		drain();
		wr(8'h20, 0, 1'b1);
		wr(8'h22, 2, 1'b1);
		drain();
		rd(8'hFD, 5);
		rd(8'($random(seed)), 3);
		u_mst.stop_c();
		repeat (3) begin
			rd(8'($random(seed)), 2);
			u_mst.stop_c();
		end
		wrap_up();
	end
endmodule

/* File: twr_fifo.sv */
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock; read data are registered.
*/
`timescale 1ns/100ps
module twr_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	logic pop;

	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	// pop into the output register whenever it is free or being taken
	assign pop = !empty && (!out_valid_out || out_ready_in);

	// write side
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_r <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (in_valid_in && in_ready_out)
				wp_r <= wp_r + 1'b1;
			in_ready_out <= !full && !(in_valid_in && in_ready_out &&
				(wp_r[AW-1:0] + 1'b1 == rp_r[AW-1:0]) && !pop);
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_in) begin
		if (in_valid_in && in_ready_out)
			mem_r[wp_r[AW-1:0]] <= in_data_in;
	end

	// read side, registered output
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rp_r <= '0;
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else begin
			if (pop) begin
				out_data_out <= mem_r[rp_r[AW-1:0]];
				out_valid_out <= 1'b1;
				rp_r <= rp_r + 1'b1;
			end else if (out_ready_in) begin
				out_valid_out <= 1'b0;
			end
		end
	end
endmodule

/* File: twr_master.sv */
/*
 Behavioural bus master for the two-wire slave.
 Assumes a pull-up wire resolved by the bench; 80 ns bit period.
*/
`timescale 1ns/100ps
module twr_master (
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_out
);
	// ----------------------------------------
	// bit level, clock stands high between frames
	// ----------------------------------------
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// data set while clock low, sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		sda_oe_out = !b;
		#20 scl_out = 1'b1;
		#20 r = sda_in;
		#20 scl_out = 1'b0;
		#20;
	endtask
	// start or repeated start: release, clock high, then pull low
	task automatic start_c();
		sda_oe_out = 1'b0;
		#20 scl_out = 1'b1;
		#20 sda_oe_out = 1'b1;
		#20 scl_out = 1'b0;
		#20;
	endtask
	// stop after the final nack or ack
	task automatic stop_c();
		sda_oe_out = 1'b1;
		#20 scl_out = 1'b1;
		#20 sda_oe_out = 1'b0;
		#40;
	endtask
	// eight bits msb first, then the ninth slot driven with a
	task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic r);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(a, r);
	endtask
endmodule

/* File: twr_pkg.sv */
/*
 Shared constants and carrier types for the two-wire register read slave.
 Assumes the core clock is 50 MHz and the link is driven by an external master.
*/
package twr_pkg;
	// ----------------------------------------
	// bus addressing
	// ----------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h36; // 0110110
	localparam logic [7:0] PAST_TOP_BYTE = 8'hFF;
	localparam logic [7:0] PTR_TOP = 8'hFF;
	localparam logic [3:0] ACK_BIT_IDX = 4'h8;
	localparam logic [2:0] MSB_IDX = 3'h7;
	localparam int FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;

	// register file write request carried to the user side
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} wr_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_RACK,
		ST_IGNORE
	} link_state_t;
endpackage

/* File: twr_slave.sv */
/*
 Two-wire register slave: address match, pointer write, 16-bit register writes
 through a FIFO, and sequential reads from a user-side register image.
 Assumes SCL is the link clock (idles high, may stop outside frames) and that
 SDA input is sampled on SCL edges; the user side supplies read data combinationally
 from rd_addr_out within one SCL high phase (byte taken into tx_r on the falling SCL edge that ends it).
*/
// How it works
// - reading starts with the byte at the pointer, then moves to the next location.
// - the pointer steps after every returned byte below the top address so the next byte follows the ack at once.
// - reading beyond the top address returns all-ones bytes.
// - reserved locations give whatever the user side returns, unchecked.
// - a nack from the master ends the read and the slave lets go of the data line.
// - a write counts only when both bytes of a register arrive; a lone byte is dropped.
// - only the fixed address 0110110 is acknowledged, in the slot after the direction bit.
// - the receiver acks by pulling data low through the ninth clock, nacks by releasing it.
// - bytes go msb first; the even address holds the high byte, the odd the low byte.
`timescale 1ns/100ps
module twr_slave #(
	parameter int FIFO_WORDS = twr_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic scl_clk_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic [7:0] rd_addr_out,
	input wire logic [7:0] rd_data_in,
	output twr_pkg::wr_req_t wr_req_out,
	output logic wr_valid_out,
	input wire logic wr_ready_in,
	output logic busy_out
);
	// ----------------------------------------
	// start / stop detection
	// ----------------------------------------
	// sda edges while scl high; flops clocked by sda itself, start cleared by the next scl rise, stop by an sda rise with scl low
	logic start_tgl_r;
	logic stop_seen_r;
	logic start_seen_r;
	logic start_ack_r;
	always_ff @(negedge sda_in or negedge nrst_in) begin
		if (!nrst_in)
			start_tgl_r <= 1'b0;
		else if (scl_clk_in)
			start_tgl_r <= !start_tgl_r;
	end
	always_ff @(posedge scl_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			start_ack_r <= 1'b0;
		else
			start_ack_r <= start_tgl_r;
	end
	assign start_seen_r = start_tgl_r ^ start_ack_r; // first scl rise after a start
	always_ff @(posedge sda_in or negedge nrst_in) begin
		if (!nrst_in)
			stop_seen_r <= 1'b0;
		else
			stop_seen_r <= scl_clk_in; // stop when scl high, cleared by an sda rise with scl low
	end

	// ----------------------------------------
	// link side, scl domain
	// ----------------------------------------
	twr_pkg::link_state_t st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] ptr_r;
	logic rnw_r;
	logic hi_have_r;
	logic [7:0] hi_byte_r;
	logic [7:0] tx_r;
	logic [7:0] rptr_r;
	logic wtgl_r;
	twr_pkg::wr_req_t wreq_r;
	logic [7:0] rx_byte;
	assign rx_byte = {sh_r[6:0], sda_in};

	// receive on rising scl
	always_ff @(posedge scl_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= twr_pkg::ST_IDLE;
			bit_r <= '0;
			sh_r <= '0;
			ptr_r <= '0;
			rnw_r <= 1'b0;
			hi_have_r <= 1'b0;
			hi_byte_r <= '0;
			wtgl_r <= 1'b0;
			wreq_r <= '0;
		end else if (start_seen_r) begin
			st_r <= twr_pkg::ST_ADDR;
			bit_r <= 4'h1;
			sh_r <= {7'h00, sda_in};
			hi_have_r <= 1'b0;
		end else if (stop_seen_r) begin
			st_r <= twr_pkg::ST_IDLE;
		end else begin
			bit_r <= (bit_r == twr_pkg::ACK_BIT_IDX) ? 4'h0 : bit_r + 4'h1;
			if (bit_r < twr_pkg::ACK_BIT_IDX)
				sh_r <= rx_byte;
			case (st_r)
				twr_pkg::ST_ADDR: begin
					if (bit_r == 4'h7) begin
						rnw_r <= sda_in;
						if (sh_r[6:0] != twr_pkg::DEV_ADDR)
							st_r <= twr_pkg::ST_IGNORE;
					end else if (bit_r == twr_pkg::ACK_BIT_IDX) begin
						st_r <= rnw_r ? twr_pkg::ST_RDATA : twr_pkg::ST_PTR;
					end
				end
				twr_pkg::ST_PTR: begin
					if (bit_r == 4'h7)
						ptr_r <= rx_byte;
					else if (bit_r == twr_pkg::ACK_BIT_IDX)
						st_r <= twr_pkg::ST_WDATA;
				end
				twr_pkg::ST_WDATA: begin
					if (bit_r == 4'h7) begin
						ptr_r <= ptr_r + 8'h01;
						if (!ptr_r[0]) begin
							hi_byte_r <= rx_byte;
							hi_have_r <= 1'b1;
						end else if (hi_have_r) begin
							wreq_r <= '{addr: ptr_r - 8'h01, data: {hi_byte_r, rx_byte}};
							wtgl_r <= !wtgl_r;
							hi_have_r <= 1'b0;
						end
					end
				end
				twr_pkg::ST_RDATA: begin
					if (bit_r == 4'h7)
						st_r <= twr_pkg::ST_RACK;
				end
				twr_pkg::ST_RACK: begin
					// master ack keeps reading, nack releases the line
					st_r <= sda_in ? twr_pkg::ST_IGNORE : twr_pkg::ST_RDATA;
				end
				default: begin
				end
			endcase
		end
	end

	// transmit on falling scl; pointer steps once the last bit has gone out
	logic rd_past_top_r;
	always_ff @(negedge scl_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sda_oe_out <= 1'b0;
			tx_r <= '0;
			rd_past_top_r <= 1'b0;
		end else begin
			sda_oe_out <= 1'b0;
			if (st_r == twr_pkg::ST_ADDR && bit_r == twr_pkg::ACK_BIT_IDX) begin
				sda_oe_out <= 1'b1;
				tx_r <= rd_past_top_r ? twr_pkg::PAST_TOP_BYTE : rd_data_in;
			end else if ((st_r == twr_pkg::ST_PTR || st_r == twr_pkg::ST_WDATA) &&
				bit_r == twr_pkg::ACK_BIT_IDX) begin
				sda_oe_out <= 1'b1;
			end else if (st_r == twr_pkg::ST_RDATA) begin
				sda_oe_out <= !tx_r[twr_pkg::MSB_IDX - bit_r[2:0]];
				if (bit_r == 4'h7) begin
					if (rptr_r == twr_pkg::PTR_TOP)
						rd_past_top_r <= 1'b1;
				end
			end else if (st_r == twr_pkg::ST_RACK) begin
				tx_r <= rd_past_top_r ? twr_pkg::PAST_TOP_BYTE : rd_data_in;
			end
			if (st_r == twr_pkg::ST_IDLE || st_r == twr_pkg::ST_PTR)
				rd_past_top_r <= 1'b0;
		end
	end
	assign sda_out = 1'b0; // open drain, only ever pulls low

	// read pointer, stepped on the rising edge that takes the eighth bit
	always_ff @(posedge scl_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rptr_r <= '0;
		else if (st_r == twr_pkg::ST_PTR && bit_r == 4'h7)
			rptr_r <= rx_byte;
		else if (st_r == twr_pkg::ST_RDATA && bit_r == 4'h7 && rptr_r != twr_pkg::PTR_TOP)
			rptr_r <= rptr_r + 8'h01;
	end
	assign rd_addr_out = rptr_r;

	// ----------------------------------------
	// crossing into the core domain
	// ----------------------------------------
	// word is stable long before the toggle is seen, so toggle sync is enough
	logic [2:0] wsync_r;
	logic fifo_in_ready;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			wsync_r <= '0;
		else
			wsync_r <= {wsync_r[1:0], wtgl_r};
	end
	// busy reflects a frame in ST_ADDR or an address-matched state, two-flop synchronised
	// the link clock stands still after a stop, so the state never sees it;
	// the stop level is synchronised too and ends busy on its own
	logic [1:0] bsync_r;
	logic [1:0] ssync_r;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bsync_r <= '0;
			ssync_r <= '0;
			busy_out <= 1'b0;
		end else begin
			bsync_r <= {bsync_r[0], st_r != twr_pkg::ST_IDLE && st_r != twr_pkg::ST_IGNORE};
			ssync_r <= {ssync_r[0], stop_seen_r};
			busy_out <= bsync_r[1] && !ssync_r[1];
		end
	end

	twr_fifo #(
		.WIDTH($bits(twr_pkg::wr_req_t)),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.in_data_in(wreq_r),
		.in_valid_in(wsync_r[2] ^ wsync_r[1]),
		.in_ready_out(fifo_in_ready),
		.out_data_out(wr_req_out),
		.out_valid_out(wr_valid_out),
		.out_ready_in(wr_ready_in)
	);
endmodule

/* File: twr_slave_sva.sv */
/*
 Port checker for the two-wire register slave.
 Bound to every twr_slave instance; sees only its ports.
*/
`timescale 1ns/100ps
module twr_slave_chk (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic scl_clk_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire twr_pkg::wr_req_t wr_req_out,
	input wire logic wr_valid_out,
	input wire logic wr_ready_in,
	input wire logic busy_out
);
	// ----------------------------------------
	// link events seen from the core clock
	// ----------------------------------------
	logic sda_q_r;
	// previous data level, for stop detection
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) sda_q_r <= 1'b1;
		else sda_q_r <= sda_in;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence stop_s; scl_clk_in && sda_in && !sda_q_r; endsequence
	sequence stall_s; wr_valid_out && !wr_ready_in; endsequence
	drive_low_a: assert property (sda_out == 1'b0)
		else $error("data pin not driven low");
	oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
		else $error("drive changed with clock high");
	oe_owner_a: assert property ($rose(sda_oe_out) |-> ##[0:6] busy_out)
		else $error("drive without frame");
	stop_idle_a: assert property (stop_s |-> ##[1:6] !busy_out)
		else $error("busy after stop");
	wr_hold_a: assert property (stall_s |=> wr_valid_out && $stable(wr_req_out))
		else $error("write word dropped while stalled");
	wr_even_a: assert property (wr_valid_out |-> !wr_req_out.addr[0])
		else $error("write word at odd address");
	wr_drop_a: assert property ($fell(wr_valid_out) |-> $past(wr_ready_in))
		else $error("valid fell without ready");
	rst_quiet_a: assert property (disable iff (1'b0)
		!nrst_in |-> !sda_oe_out && !wr_valid_out && !busy_out) else $error("reset not quiet");
endmodule
bind twr_slave twr_slave_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
	.scl_clk_in(scl_clk_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.wr_req_out(wr_req_out), .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in),
	.busy_out(busy_out));
